// File: design/bcr_config_bank.sv
/*
 * Configuration register bank of the barometer: threshold, interface
 * control, identity and main control, plus the result hold and the rate
 * timer they steer. Assumes the serial front end delivers one-cycle read
 * and write strobes and the analog chain reports each acquisition by a
 * one-cycle done pulse some cycles after its start pulse.
 */
module bcr_config_bank #(
    parameter logic [7:0]  IDENTITY_CODE = 8'h5a, // Arbitrary value
    parameter int unsigned PERIOD_1HZ    = bcr_pkg::RATE1_CYC,
    parameter int unsigned PERIOD_10HZ   = bcr_pkg::RATE2_CYC,
    parameter int unsigned PERIOD_25HZ   = bcr_pkg::RATE3_CYC,
    parameter int unsigned PERIOD_50HZ   = bcr_pkg::RATE4_CYC,
    parameter int unsigned PERIOD_75HZ   = bcr_pkg::RATE5_CYC,
    parameter int unsigned PERIOD_100HZ  = bcr_pkg::RATE6_CYC,
    parameter int unsigned PERIOD_200HZ  = bcr_pkg::RATE7_CYC
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 arst_n_i,
    input  wire bcr_pkg::bcr_req_t    req_i,
    output logic [7:0]                rdata_o,
    input  wire logic                 diff_irq_enable_i,
    input  wire logic                 high_event_enable_i,
    input  wire logic                 low_event_enable_i,
    input  wire logic                 low_noise_request_i,
    input  wire logic                 one_shot_set_i,
    input  wire logic                 acq_done_i,
    input  wire bcr_pkg::bcr_sample_t sample_i,
    output logic                      acq_start_o,
    output logic                      one_shot_o,
    output logic                      power_down_o,
    output logic                      low_noise_active_o,
    output logic [4:0]                bandwidth_div_o,
    output bcr_pkg::bcr_pads_t        pads_o,
    output logic                      irq_gen_enable_o,
    output logic                      irq_high_o,
    output logic                      irq_low_o,
    output logic [14:0]               threshold_o
);

    // Stored registers
    logic [7:0]          threshold_low;
    logic [7:0]          threshold_high;
    logic [7:0]          interface_control;
    logic [7:0]          main_control;
    logic [1:0]          status;
    logic [23:0]         press_result;
    logic [15:0]         temp_result;
    logic                result_held;
    bcr_pkg::bcr_mode_t  mode;
    logic [bcr_pkg::TIMER_W-1:0] rate_timer;
    logic                acq_busy;

    // Decoded helpers
    logic [2:0]  rate_sel;
    logic [14:0] threshold_field;
    logic        wr_hit;
    logic        rd_hit;
    logic        result_update;
    logic        top_read;
    logic        temp_top_read;
    logic [23:0] thr_pos;
    logic [23:0] thr_neg;

    // Cycles between acquisitions for each rate code
    function automatic logic [bcr_pkg::TIMER_W-1:0] rate_period(input logic [2:0] code);
        int unsigned p;
        unique case (code)
            3'b001:  p = PERIOD_1HZ;
            3'b010:  p = PERIOD_10HZ;
            3'b011:  p = PERIOD_25HZ;
            3'b100:  p = PERIOD_50HZ;
            3'b101:  p = PERIOD_75HZ;
            3'b110:  p = PERIOD_100HZ;
            3'b111:  p = PERIOD_200HZ;
            default: p = 1;
        endcase
        return bcr_pkg::TIMER_W'(p - 1);
    endfunction : rate_period

    // Bandwidth divisor from the filter bits
    function automatic logic [4:0] bw_divisor(input logic en, input logic sel);
        logic [4:0] d;
        d = !en ? bcr_pkg::BW_DIV_OFF : (sel ? bcr_pkg::BW_DIV_LOW : bcr_pkg::BW_DIV_MID);
        return d;
    endfunction : bw_divisor

    // Field views and strobes
    assign rate_sel        = main_control[bcr_pkg::MC_RATE_MSB:bcr_pkg::MC_RATE_LSB];
    assign threshold_field = {threshold_high[6:0], threshold_low};
    assign wr_hit          = req_i.wr;
    assign rd_hit          = req_i.rd;
    assign top_read        = rd_hit && (req_i.addr == bcr_pkg::OFS_PRESS_TOP);
    assign temp_top_read   = rd_hit && (req_i.addr == bcr_pkg::OFS_TEMP_H);
    // Held results drop new samples rather than tear a read in progress
    assign result_update   = acq_done_i && acq_busy
                             && !(main_control[bcr_pkg::MC_BLOCK_HOLD] && result_held);
    // Threshold scaled to pressure counts, positive and negative
    assign thr_pos = {1'b0, threshold_field, 8'h00};
    assign thr_neg = 24'(-$signed(thr_pos));

    // Threshold registers
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            threshold_low  <= bcr_pkg::RST_THRESHOLD_LOW;
            threshold_high <= bcr_pkg::RST_THRESHOLD_HIGH;
        end
        else if (wr_hit)
        begin
            if (req_i.addr == bcr_pkg::OFS_THRESHOLD_LOW)
                threshold_low <= req_i.wdata;
            if (req_i.addr == bcr_pkg::OFS_THRESHOLD_HIGH)
                threshold_high <= req_i.wdata & bcr_pkg::WMASK_THRESHOLD_HIGH;
        end
    end

    // Interface control; unused bits 6 and 5 stay zero
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            interface_control <= bcr_pkg::RST_INTERFACE_CONTROL;
        else if (wr_hit && req_i.addr == bcr_pkg::OFS_INTERFACE_CONTROL)
            interface_control <= req_i.wdata & bcr_pkg::WMASK_INTERFACE_CONTROL;
    end

    // Main control; kept through power-down
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            main_control <= bcr_pkg::RST_MAIN_CONTROL;
        else if (wr_hit && req_i.addr == bcr_pkg::OFS_MAIN_CONTROL)
            main_control <= req_i.wdata & bcr_pkg::WMASK_MAIN_CONTROL;
    end

    // Acquisition sequencer
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mode        <= bcr_pkg::BCR_POWER_DOWN;
            rate_timer  <= '0;
            acq_start_o <= 1'b0;
            acq_busy    <= 1'b0;
        end
        else
        begin
            acq_start_o <= 1'b0;
            if (acq_done_i)
                acq_busy <= 1'b0;
            unique case (mode)
                bcr_pkg::BCR_POWER_DOWN:
                begin
                    // Only a one-shot request starts an acquisition here; one still in flight can update outputs
                    if (rate_sel != bcr_pkg::RATE_POWER_DOWN)
                    begin
                        mode       <= bcr_pkg::BCR_CONTINUOUS;
                        rate_timer <= '0;
                    end
                    else if (one_shot_set_i)
                    begin
                        mode        <= bcr_pkg::BCR_ONE_SHOT;
                        acq_start_o <= 1'b1;
                        acq_busy    <= 1'b1;
                    end
                end
                bcr_pkg::BCR_ONE_SHOT:
                begin
                    if (acq_done_i)
                        mode <= bcr_pkg::BCR_POWER_DOWN;
                end
                bcr_pkg::BCR_CONTINUOUS:
                begin
                    if (rate_sel == bcr_pkg::RATE_POWER_DOWN)
                    begin
                        mode       <= bcr_pkg::BCR_POWER_DOWN;
                        rate_timer <= '0;
                    end
                    else if (rate_timer == '0)
                    begin
                        // A slow chain simply skips a tick instead of overlapping
                        rate_timer <= rate_period(rate_sel);
                        if (!acq_busy || acq_done_i)
                        begin
                            acq_start_o <= 1'b1;
                            acq_busy    <= 1'b1;
                        end
                    end
                    else
                        rate_timer <= rate_timer - 1'b1;
                end
                default:
                    mode <= bcr_pkg::BCR_POWER_DOWN;
            endcase
        end
    end

    // One-shot bit: set by request in power-down, cleared on completion
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            one_shot_o <= 1'b0;
        else if (mode == bcr_pkg::BCR_POWER_DOWN && one_shot_set_i
                 && rate_sel == bcr_pkg::RATE_POWER_DOWN)
            one_shot_o <= 1'b1;
        else if (mode == bcr_pkg::BCR_ONE_SHOT && acq_done_i)
            one_shot_o <= 1'b0;
    end

    // Output data and block-update hold
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            press_result <= '0;
            temp_result  <= '0;
            result_held  <= 1'b0;
        end
        else
        begin
            if (result_update)
            begin
                press_result <= sample_i.pressure;
                temp_result  <= sample_i.temp;
            end
            // Reading the pressure top byte releases the hold; a new hold wins
            if (result_update && main_control[bcr_pkg::MC_BLOCK_HOLD])
                result_held <= 1'b1;
            else if (top_read || !main_control[bcr_pkg::MC_BLOCK_HOLD])
                result_held <= 1'b0;
        end
    end

    // New-data flags; a new sample wins over a clearing read
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            status <= '0;
        else
        begin
            if (result_update)
                status <= 2'b11;
            else
            begin
                if (top_read)
                    status[bcr_pkg::ST_PRESS_NEW] <= 1'b0;
                if (temp_top_read)
                    status[bcr_pkg::ST_TEMP_NEW] <= 1'b0;
            end
        end
    end

    // Threshold events, evaluated on each accepted sample
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_high_o <= 1'b0;
            irq_low_o  <= 1'b0;
        end
        else if (!diff_irq_enable_i)
        begin
            irq_high_o <= 1'b0;
            irq_low_o  <= 1'b0;
        end
        else if (result_update)
        begin
            irq_high_o <= high_event_enable_i
                          && ($signed(sample_i.press_diff) > $signed(thr_pos));
            irq_low_o  <= low_event_enable_i
                          && ($signed(sample_i.press_diff) < $signed(thr_neg));
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 8'h00;
        else if (rd_hit)
        begin
            unique case (req_i.addr)
                bcr_pkg::OFS_THRESHOLD_LOW:     rdata_o <= threshold_low;
                bcr_pkg::OFS_THRESHOLD_HIGH:    rdata_o <= threshold_high;
                bcr_pkg::OFS_INTERFACE_CONTROL: rdata_o <= interface_control;
                bcr_pkg::OFS_IDENTITY:          rdata_o <= IDENTITY_CODE;
                bcr_pkg::OFS_MAIN_CONTROL:      rdata_o <= main_control;
                bcr_pkg::OFS_STATUS:            rdata_o <= {6'h00, status};
                bcr_pkg::OFS_PRESS_XL:          rdata_o <= press_result[7:0];
                bcr_pkg::OFS_PRESS_L:           rdata_o <= press_result[15:8];
                bcr_pkg::OFS_PRESS_TOP:         rdata_o <= press_result[23:16];
                bcr_pkg::OFS_TEMP_L:            rdata_o <= temp_result[7:0];
                bcr_pkg::OFS_TEMP_H:            rdata_o <= temp_result[15:8];
                default:                        rdata_o <= 8'h00;
            endcase
        end
    end

    // Decoded settings, registered so every output leaves a flip-flop
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            power_down_o       <= 1'b1;
            low_noise_active_o <= 1'b0;
            bandwidth_div_o    <= bcr_pkg::BW_DIV_OFF;
            irq_gen_enable_o   <= 1'b0;
            threshold_o        <= '0;
        end
        else
        begin
            power_down_o       <= (mode == bcr_pkg::BCR_POWER_DOWN);
            low_noise_active_o <= low_noise_request_i
                                  && (rate_sel < bcr_pkg::RATE_100HZ_CODE);
            bandwidth_div_o    <= bw_divisor(main_control[bcr_pkg::MC_FILTER_ENABLE],
                                             main_control[bcr_pkg::MC_FILTER_BW_SEL]);
            irq_gen_enable_o   <= diff_irq_enable_i
                                  && (high_event_enable_i || low_event_enable_i);
            threshold_o        <= threshold_field;
        end
    end

    // Pad and protocol controls
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            pads_o <= '{irq_pad_oe: 1'b0, data_line_pullup_enable: 1'b0,
                        serial_out_pullup_enable: 1'b0, irq_pad_pulldown_on: 1'b1,
                        i3c_enable: 1'b1, i2c_enable: 1'b1, spi_three_wire: 1'b0};
        else
        begin
            // Pad enable matters only while I3C is the active protocol
            pads_o.irq_pad_oe <= interface_control[bcr_pkg::IFC_IRQ_PAD_I3C_EN]
                                 && !interface_control[bcr_pkg::IFC_I3C_DISABLE];
            pads_o.data_line_pullup_enable  <=
                interface_control[bcr_pkg::IFC_DATA_LINE_PULLUP];
            pads_o.serial_out_pullup_enable <=
                interface_control[bcr_pkg::IFC_SERIAL_OUT_PULLUP];
            pads_o.irq_pad_pulldown_on <=
                !interface_control[bcr_pkg::IFC_IRQ_PAD_PULLDOWN_DIS];
            pads_o.i3c_enable <= !interface_control[bcr_pkg::IFC_I3C_DISABLE];
            pads_o.i2c_enable <= !interface_control[bcr_pkg::IFC_I2C_DISABLE];
            pads_o.spi_three_wire <= main_control[bcr_pkg::MC_SPI_WIRE_SEL];
        end
    end

endmodule : bcr_config_bank

// File: shared/bcr_pkg.sv
/*
 * Shared constants and carrier types of the barometer configuration bank.
 * Assumes one 25 MHz clock and a byte-wide register port driven by the
 * serial front end, which has already turned bus frames into strobes.
 */
package bcr_pkg;

    // Register offsets on the 7-bit register address
    localparam logic [6:0] OFS_THRESHOLD_LOW     = 7'h0c;
    localparam logic [6:0] OFS_THRESHOLD_HIGH    = 7'h0d;
    localparam logic [6:0] OFS_INTERFACE_CONTROL = 7'h0e;
    localparam logic [6:0] OFS_IDENTITY          = 7'h0f;
    localparam logic [6:0] OFS_MAIN_CONTROL      = 7'h10;
    localparam logic [6:0] OFS_STATUS            = 7'h27;
    localparam logic [6:0] OFS_PRESS_XL          = 7'h28;
    localparam logic [6:0] OFS_PRESS_L           = 7'h29;
    localparam logic [6:0] OFS_PRESS_TOP         = 7'h2a;
    localparam logic [6:0] OFS_TEMP_L            = 7'h2b;
    localparam logic [6:0] OFS_TEMP_H            = 7'h2c;

    // Reset values
    localparam logic [7:0] RST_THRESHOLD_LOW     = 8'h00;
    localparam logic [7:0] RST_THRESHOLD_HIGH    = 8'h00;
    localparam logic [7:0] RST_INTERFACE_CONTROL = 8'h00;
    localparam logic [7:0] RST_MAIN_CONTROL      = 8'h00;

    // Writable bit masks; fixed-zero bits are cleared on write
    localparam logic [7:0] WMASK_THRESHOLD_HIGH    = 8'h7f;
    localparam logic [7:0] WMASK_INTERFACE_CONTROL = 8'h9f;
    localparam logic [7:0] WMASK_MAIN_CONTROL      = 8'h7f;

    // Interface control fields
    localparam int IFC_IRQ_PAD_I3C_EN      = 7;
    localparam int IFC_DATA_LINE_PULLUP    = 4;
    localparam int IFC_SERIAL_OUT_PULLUP   = 3;
    localparam int IFC_IRQ_PAD_PULLDOWN_DIS = 2;
    localparam int IFC_I3C_DISABLE         = 1;
    localparam int IFC_I2C_DISABLE         = 0;

    // Main control fields
    localparam int MC_RATE_MSB        = 6;
    localparam int MC_RATE_LSB        = 4;
    localparam int MC_FILTER_ENABLE   = 3;
    localparam int MC_FILTER_BW_SEL   = 2;
    localparam int MC_BLOCK_HOLD      = 1;
    localparam int MC_SPI_WIRE_SEL    = 0;

    // Status fields
    localparam int ST_PRESS_NEW = 0;
    localparam int ST_TEMP_NEW  = 1;

    // Output rate codes
    localparam logic [2:0] RATE_POWER_DOWN = 3'b000;
    localparam logic [2:0] RATE_100HZ_CODE = 3'b110;

    // Bandwidth divisors
    localparam logic [4:0] BW_DIV_OFF  = 5'd2;
    localparam logic [4:0] BW_DIV_MID  = 5'd9;
    localparam logic [4:0] BW_DIV_LOW  = 5'd20;

    // Threshold counts are 1/16 hPa, pressure counts 1/4096 hPa
    localparam int THRESHOLD_SHIFT = 8;

    // Timing: clock rate and output rates in Hz
    localparam int unsigned CLK_HZ   = 25_000_000;
    localparam int unsigned RATE1_HZ = 1;
    localparam int unsigned RATE2_HZ = 10;
    localparam int unsigned RATE3_HZ = 25;
    localparam int unsigned RATE4_HZ = 50;
    localparam int unsigned RATE5_HZ = 75;
    localparam int unsigned RATE6_HZ = 100;
    localparam int unsigned RATE7_HZ = 200;
    localparam int unsigned RATE1_CYC = CLK_HZ / RATE1_HZ;
    localparam int unsigned RATE2_CYC = CLK_HZ / RATE2_HZ;
    localparam int unsigned RATE3_CYC = CLK_HZ / RATE3_HZ;
    localparam int unsigned RATE4_CYC = CLK_HZ / RATE4_HZ;
    localparam int unsigned RATE5_CYC = CLK_HZ / RATE5_HZ;
    localparam int unsigned RATE6_CYC = CLK_HZ / RATE6_HZ;
    localparam int unsigned RATE7_CYC = CLK_HZ / RATE7_HZ;
    localparam int TIMER_W = 25;

    // Register port request from the serial front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bcr_req_t;

    // One finished acquisition
    typedef struct packed {
        logic [23:0] pressure;
        logic [15:0] temp;
        logic [23:0] press_diff;
    } bcr_sample_t;

    // Pad and interface settings
    typedef struct packed {
        logic irq_pad_oe;
        logic data_line_pullup_enable;
        logic serial_out_pullup_enable;
        logic irq_pad_pulldown_on;
        logic i3c_enable;
        logic i2c_enable;
        logic spi_three_wire;
    } bcr_pads_t;

    typedef enum logic [1:0] {
        BCR_POWER_DOWN = 2'b00,
        BCR_ONE_SHOT   = 2'b01,
        BCR_CONTINUOUS = 2'b11
    } bcr_mode_t;

endpackage : bcr_pkg

// File: tb/bcr_acq_model.sv
/* Stand-in for the sensing chain behind the configuration bank.
   Assumes one start pulse per acquisition and a fixed conversion time. */
module bcr_acq_model #(
    parameter int LAT = 6
) (
    input  wire logic           clk_i,
    input  wire logic           arst_n_i,
    input  wire logic           start_i,
    input  wire logic [23:0]    press_i,
    input  wire logic [23:0]    diff_i,
    output logic                done_o,
    output bcr_pkg::bcr_sample_t sample_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // Conversion countdown; a fresh start restarts it
    always_ff @(posedge clk_i or negedge arst_n_i)
        if (!arst_n_i)
            cnt <= 0;
        else
            cnt <= start_i ? LAT : (cnt > 0 ? cnt - 1 : 0);
    // Sample is junk outside the done cycle, so late sampling shows up
    assign done_o   = (cnt == 1);
    assign sample_o = done_o ? {press_i, press_i[15:0], diff_i}
                             : ~{press_i, press_i[15:0], diff_i};
endmodule : bcr_acq_model

// File: tb/bcr_config_bank_monitor.sv
/* Port checker of the configuration bank.
   Assumes it is bound into bcr_config_bank and sees its ports only. */
module bcr_config_bank_monitor (
    input wire logic               ref_clk_i,
    input wire logic               arst_n_i,
    input wire bcr_pkg::bcr_req_t  req_i,
    input wire logic               diff_irq_enable_i,
    input wire logic               high_event_enable_i,
    input wire logic               low_event_enable_i,
    input wire logic               one_shot_set_i,
    input wire logic               acq_done_i,
    input wire logic               acq_start_o,
    input wire logic               one_shot_o,
    input wire logic               power_down_o,
    input wire logic [4:0]         bandwidth_div_o,
    input wire bcr_pkg::bcr_pads_t pads_o,
    input wire logic               irq_gen_enable_o,
    input wire logic [14:0]        threshold_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Writes are judged two edges on, so either register depth passes
    AST_THR_LOW: assert property (req_i.wr && req_i.addr == 7'h0c ##1 !req_i.wr
        |=> threshold_o[7:0] == $past(req_i.wdata, 2)) else $error("threshold low");
    AST_THR_HIGH: assert property (req_i.wr && req_i.addr == 7'h0d ##1 !req_i.wr
        |=> threshold_o[14:8] == $past(req_i.wdata[6:0], 2)) else $error("threshold high");
    AST_PADS: assert property (req_i.wr && req_i.addr == 7'h0e ##1 !req_i.wr
        |=> pads_o[5:1] == {$past(req_i.wdata[4:3], 2), ~$past(req_i.wdata[2:0], 2)})
        else $error("pad settings");
    AST_MAIN: assert property (req_i.wr && req_i.addr == 7'h10 ##1 !req_i.wr
        |=> pads_o[0] == $past(req_i.wdata[0], 2) && bandwidth_div_o ==
        (!$past(req_i.wdata[3], 2) ? 5'h02 : ($past(req_i.wdata[2], 2) ? 5'h14 : 5'h09)))
        else $error("main control");
    AST_IRQ_ON: assert property ((diff_irq_enable_i && (high_event_enable_i
        || low_event_enable_i)) [*2] |-> irq_gen_enable_o) else $error("irq enable on");
    AST_IRQ_OFF: assert property (!diff_irq_enable_i [*2] |-> !irq_gen_enable_o)
        else $error("irq enable off");
    AST_OS_START: assert property (one_shot_set_i && power_down_o && !one_shot_o
        |=> acq_start_o && one_shot_o) else $error("one-shot start");
    AST_OS_CLEAR: assert property (one_shot_o && acq_done_i |=> ##[0:1] !one_shot_o)
        else $error("one-shot clear");
endmodule : bcr_config_bank_monitor
bind bcr_config_bank bcr_config_bank_monitor bcr_config_bank_monitor_inst (
    .ref_clk_i, .arst_n_i, .req_i, .diff_irq_enable_i, .high_event_enable_i,
    .low_event_enable_i, .one_shot_set_i, .acq_done_i, .acq_start_o, .one_shot_o,
    .power_down_o, .bandwidth_div_o, .pads_o, .irq_gen_enable_o, .threshold_o);

// File: tb/barometer_config_registers_test.sv
/* Bench of the configuration bank, acting as host on its register port.
   Assumes bcr_acq_model stands in for the sensing chain. */
module barometer_config_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0, arst_n = 1'b0, os = 1'b0, ln = 1'b0;
    logic                 den = 1'b0, hen = 1'b0, len = 1'b0;
    logic                 done, start, one_shot, pd, lna, ien, ihi, ilo;
    logic [7:0]           rd_q;
    logic [4:0]           bw;
    logic [14:0]          thr;
    logic [23:0]          press = 24'h000000, diff = 24'h000000;
    bcr_pkg::bcr_req_t    req = '0;
    bcr_pkg::bcr_pads_t   pads;
    bcr_pkg::bcr_sample_t smp;
    int                   n_fail = 0, num_checks = 0;
    // Short periods keep every rate within a few hundred cycles; identity value arbitrary
    bcr_config_bank #(.IDENTITY_CODE(8'h3c), .PERIOD_1HZ(100), .PERIOD_10HZ(90),
        .PERIOD_25HZ(80), .PERIOD_50HZ(60), .PERIOD_75HZ(50), .PERIOD_100HZ(40),
        .PERIOD_200HZ(20))
        bcr_config_bank_inst (.ref_clk_i(clk), .arst_n_i(arst_n), .req_i(req),
        .rdata_o(rd_q), .diff_irq_enable_i(den), .high_event_enable_i(hen),
        .low_event_enable_i(len), .low_noise_request_i(ln), .one_shot_set_i(os),
        .acq_done_i(done), .sample_i(smp), .acq_start_o(start), .one_shot_o(one_shot),
        .power_down_o(pd), .low_noise_active_o(lna), .bandwidth_div_o(bw), .pads_o(pads),
        .irq_gen_enable_o(ien), .irq_high_o(ihi), .irq_low_o(ilo), .threshold_o(thr));
    bcr_acq_model bcr_acq_model_inst (.clk_i(clk), .arst_n_i(arst_n), .start_i(start),
        .press_i(press), .diff_i(diff), .done_o(done), .sample_o(smp));
    always #20 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk) req <= '{1'b1, 1'b0, a, v};
        @(posedge clk) req <= '0;
    endtask : wr
    // Read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [6:0] a, input logic [7:0] v);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 chk(rd_q, v);
    endtask : rd
    task automatic shot(input logic [23:0] p);
        int k;
        press <= p;
        @(posedge clk) os <= 1'b1;
        @(posedge clk) os <= 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1 chk({k < 40, one_shot, pd}, 3'b101);
    endtask : shot
    task automatic t_reset;
        chk({pads, bw, pd, thr}, {7'b0001110, 5'h02, 1'b1, 15'h0000});
        rd(7'h0c, 8'h00);
        rd(7'h0d, 8'h00);
        rd(7'h0e, 8'h00);
        rd(7'h10, 8'h00);
    endtask : t_reset
    task automatic t_regs;
        wr(7'h0d, 8'hff);
        wr(7'h0c, 8'h34);
        rd(7'h0d, 8'h7f);
        chk(thr, 15'h7f34);
        wr(7'h0e, 8'hff);
        rd(7'h0e, 8'h9f);
        chk(pads[6:1], 6'b011000);
        wr(7'h0e, 8'h80);
        rd(7'h0e, 8'h80);
        chk(pads[6:1], 6'b100111);
        wr(7'h0f, 8'h00);
        rd(7'h0f, 8'h3c);
        rd(7'h05, 8'h00);
        wr(7'h10, 8'hff);
        rd(7'h10, 8'h7f);
        wr(7'h10, 8'h00);
    endtask : t_regs
    // Enables and difference set together, then one acquisition
    task automatic irq_set(input logic [2:0] en, input logic [23:0] d);
        @(posedge clk) {den, hen, len} <= en;
        diff <= d;
        shot(24'h000000);
    endtask : irq_set
    // Threshold 1 is 256 pressure counts; compare is strict
    task automatic t_irq;
        wr(7'h0d, 8'h00);
        wr(7'h0c, 8'h01);
        irq_set(3'b111, 24'd256);
        chk({ien, ihi, ilo}, 3'b100);
        irq_set(3'b111, 24'd257);
        chk({ihi, ilo}, 2'b10);
        irq_set(3'b111, 24'hfffeff);
        chk({ihi, ilo}, 2'b01);
        irq_set(3'b011, 24'hfffeff);
        chk({ien, ihi, ilo}, 3'b000);
    endtask : t_irq
    task automatic t_hold;
        wr(7'h10, 8'h02);
        rd(7'h2a, 8'h00);
        shot(24'habcdef);
        shot(24'h123456);
        rd(7'h28, 8'hef);
        rd(7'h2a, 8'hab);
        shot(24'h123456);
        rd(7'h27, 8'h03);
        rd(7'h28, 8'h56);
        wr(7'h10, 8'h00);
    endtask : t_hold
    // Low-noise wish stays on, so only the two top rates may drop it
    task automatic t_rate;
        int r;
        int n;
        @(posedge clk) ln <= 1'b1;
        for (r = 1; r < 8; r++)
        begin
            wr(7'h10, {1'b0, r[2:0], r[0], r[1], 2'b01});
            n = 0;
            // Pulse counted once settled, not in the edge that launches it
            repeat (120)
            begin
                @(posedge clk);
                #1 n += int'(start);
            end
            #1 chk({n != 0, lna, pads[0], pd}, {1'b1, r < 6, 2'b10});
            chk(bw, r[0] ? (r[1] ? 5'h14 : 5'h09) : 5'h02);
        end
        wr(7'h10, 8'h00);
        repeat (150) @(posedge clk);
        #1 chk({pd, start}, 2'b10);
    endtask : t_rate
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        #1 t_reset;
        t_regs;
        t_irq;
        t_hold;
        t_rate;
        summarize;
    end
    // Watchdog at 10000 cycles, well past the roughly 1100 cycles the tests need
    initial
    begin
        #400000;
        n_fail++;
        summarize;
    end
endmodule : barometer_config_registers_test
